// >>> hw/pwr_pkg.sv
package pwr_pkg;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
    localparam logic [9:0] IDX_CLOCK_SELECT  = 10'h08f;
    localparam logic [9:0] IDX_WAKE_MASK     = 10'h09f;
    localparam logic [9:0] IDX_POWER_MODE    = 10'h0c4;
    localparam logic [9:0] IDX_TIMED_ACCESS  = 10'h0c9;

    // ==========================================================
    // field positions
    localparam int PC_IDLE_BIT  = 0;
    localparam int PC_STOP_BIT  = 1;
    localparam int PC_SLEEP_BIT = 2;
    localparam int PM_SWB_BIT   = 5;
    localparam int PM_CD_LSB    = 6;
    localparam int CS_DLY_LSB   = 5;
    localparam int CS_SEL_LSB   = 0;

    // ==========================================================
    // reset values and codes
    localparam logic [7:0] WAKE_MASK_RST = 8'hff;
    localparam logic [1:0] CD_FULL       = 2'h1;
    localparam logic [1:0] CD_SLOW       = 2'h3;
    localparam logic [2:0] WAKE_DELAY_SEL_RST     = 3'h6;
    localparam logic [1:0] CLKSEL_INTERNAL_OSC   = 2'h0;
    localparam logic [7:0] TB_KEY1       = 8'haa;
    localparam logic [7:0] TB_KEY2       = 8'h55;
    localparam logic [7:0] TB_CLOSE      = 8'h00;
    localparam logic [8:0] TB_WINDOW     = 9'h100;
    localparam logic [8:0] SWB_SRC_SEL   = 9'h1df;

    // ==========================================================
    // timing
    localparam int SLOW_DIV      = 257;
    localparam int WAKE_DLY_BASE = 128;
    localparam int NUM_SRC       = 9;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_STOP,
        MODE_WAKE
    } mode_t;

    typedef struct packed {
        mode_t       mode;
        logic [7:0]  mask;
        logic [1:0]  cd;
        logic        slow;
        logic        switchback_enable;
        logic        idle;
        logic        stop;
        logic        sleep;
        logic [2:0]  wake_delay_sel;
        logic [1:0]  clksel;
        logic        tb_armed;
        logic [8:0]  tb_cnt;
        logic [13:0] dly_cnt;
        logic [8:0]  src_q;
        logic        rx_q;
        logic        wake_vec;
        logic [3:0]  wake_id;
        logic        cpu_clk_en;
        logic        periph_clk_en;
        logic        osc_en;
        logic        regulator_on;
        logic        vec_req;
        logic [3:0]  vec_id;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;

endpackage

// >>> hw/slow_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none

module slow_tick_gen #(
    parameter int DIV = pwr_pkg::SLOW_DIV
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic run,
    output logic      tick
);

    logic [8:0] cnt_reg;

    // ==========================================================
    // one enable pulse every DIV cycles while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 9'h000;
            tick    <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg <= 9'h000;
            tick    <= 1'b0;
        end
        else
        begin
            tick <= (cnt_reg == 9'(DIV - 1));
            if (cnt_reg == 9'(DIV - 1))
                cnt_reg <= 9'h000;
            else
                cnt_reg <= cnt_reg + 9'h001;
        end
    end

endmodule

`default_nettype wire

// >>> hw/power_mode_wake_control.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module power_mode_wake_control #(
    parameter int WAKE_BASE = pwr_pkg::WAKE_DLY_BASE
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wdt_reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // interrupt sources
    input  wire logic [8:0]  ext_pin_n,
    input  wire logic [8:0]  periph_flag,
    input  wire logic [8:0]  irq_enable,
    input  wire logic [8:0]  irq_blocked,
    // uart0 activity
    input  wire logic        uart_rx_line,
    input  wire logic        uart_rx_enable,
    input  wire logic        uart_tx_load,
    // clock and power controls
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             osc_en,
    output logic             regulator_on,
    output logic [1:0]       clk_src_sel,
    output logic             slow_clock_mode,
    output logic             vec_req,
    output logic [3:0]       vec_id
);

    pwr_pkg::state_t st_reg;
    pwr_pkg::state_t st_next;
    logic            tick;
    logic [8:0]      src_act;
    logic [8:0]      src_edge;
    logic [8:0]      wake_sel;
    logic            wake_any;
    logic            idle_exit;
    logic            swb_hit;
    logic            tb_open;
    logic            wr_acc;
    logic [9:0]      idx;

    localparam pwr_pkg::state_t ST_RST = '{
        mode:          pwr_pkg::MODE_RUN,
        mask:          pwr_pkg::WAKE_MASK_RST,
        cd:            pwr_pkg::CD_FULL,
        slow:          1'b0,
        switchback_enable:           1'b0,
        idle:          1'b0,
        stop:          1'b0,
        sleep:         1'b0,
        wake_delay_sel:         pwr_pkg::WAKE_DELAY_SEL_RST,
        clksel:        pwr_pkg::CLKSEL_INTERNAL_OSC,
        tb_armed:      1'b0,
        tb_cnt:        9'h000,
        dly_cnt:       14'h0000,
        src_q:         9'h000,
        rx_q:          1'b1,
        wake_vec:      1'b0,
        wake_id:       4'h0,
        cpu_clk_en:    1'b1,
        periph_clk_en: 1'b1,
        osc_en:        1'b1,
        regulator_on:  1'b1,
        vec_req:       1'b0,
        vec_id:        4'h0,
        pready:        1'b0,
        pslverr:       1'b0,
        prdata:        32'h0000_0000
    };

    // ==========================================================
    // helpers
    function automatic logic [8:0] mask_to_src(input logic [7:0] m);
        mask_to_src = {m[7:5], 1'b0, m[4:0]};
    endfunction

    function automatic logic [3:0] first_src(input logic [8:0] v);
        first_src = 4'h0;
        for (int i = pwr_pkg::NUM_SRC - 1; i >= 0; i--)
            if (v[i])
                first_src = 4'(i);
    endfunction

    function automatic logic [13:0] wake_delay(input logic [2:0] code);
        if (code == 3'h0)
            wake_delay = 14'h0000;
        else
            wake_delay = 14'(WAKE_BASE << (code - 3'h1));
    endfunction

    slow_tick_gen #(
        .DIV (pwr_pkg::SLOW_DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (st_reg.slow),
        .tick    (tick)
    );

    // ==========================================================
    // source conditioning
    // pins active low, flags active high
    assign src_act  = ~ext_pin_n | periph_flag;
    assign src_edge = src_act & ~st_reg.src_q;
    assign wake_sel = src_edge & mask_to_src(st_reg.mask);
    assign wake_any = |wake_sel;
    // idle leaves on any enabled interrupt
    assign idle_exit = |(src_act & irq_enable);
    assign swb_hit = (|(src_edge & irq_enable & ~irq_blocked
                        & pwr_pkg::SWB_SRC_SEL))
                   | (uart_rx_enable & st_reg.rx_q & ~uart_rx_line)
                   | uart_tx_load;
    assign tb_open = (st_reg.tb_cnt != 9'h000);
    assign idx     = paddr[11:2];
    assign wr_acc  = psel & penable & st_reg.pready & pwrite;

    // ==========================================================
    // next state
    always_comb
    begin
        st_next         = st_reg;
        st_next.src_q   = src_act;
        st_next.rx_q    = uart_rx_line;
        st_next.vec_req = 1'b0;
        st_next.pready  = psel & ~penable;
        st_next.pslverr = 1'b0;
        st_next.prdata  = 32'h0000_0000;

        // timed access b window
        if (tb_open)
            st_next.tb_cnt = st_reg.tb_cnt - 9'h001;

        // read path, answered in the access cycle
        if (psel && !penable)
        begin
            unique case (idx)
                pwr_pkg::IDX_POWER_CONTROL:
                begin
                    st_next.prdata[pwr_pkg::PC_IDLE_BIT]  = st_reg.idle;
                    st_next.prdata[pwr_pkg::PC_STOP_BIT]  = st_reg.stop;
                    st_next.prdata[pwr_pkg::PC_SLEEP_BIT] = st_reg.sleep;
                end
                pwr_pkg::IDX_POWER_MODE:
                begin
                    st_next.prdata[pwr_pkg::PM_CD_LSB +: 2] = st_reg.cd;
                    st_next.prdata[pwr_pkg::PM_SWB_BIT]     = st_reg.switchback_enable;
                end
                pwr_pkg::IDX_CLOCK_SELECT:
                begin
                    st_next.prdata[pwr_pkg::CS_DLY_LSB +: 3] = st_reg.wake_delay_sel;
                    st_next.prdata[pwr_pkg::CS_SEL_LSB +: 2] = st_reg.clksel;
                end
                pwr_pkg::IDX_WAKE_MASK:
                    st_next.prdata[7:0] = st_reg.mask;
                pwr_pkg::IDX_TIMED_ACCESS:
                    st_next.prdata[0] = tb_open;
                default:
                    st_next.pslverr = 1'b1;
            endcase
        end

        // register writes
        if (wr_acc)
        begin
            unique case (idx)
                pwr_pkg::IDX_POWER_CONTROL:
                begin
                    st_next.idle  = pwdata[pwr_pkg::PC_IDLE_BIT];
                    st_next.stop  = pwdata[pwr_pkg::PC_STOP_BIT];
                    st_next.sleep = pwdata[pwr_pkg::PC_SLEEP_BIT];
                end
                pwr_pkg::IDX_POWER_MODE:
                begin
                    // divider field picks slow or full speed
                    st_next.cd  = pwdata[pwr_pkg::PM_CD_LSB +: 2];
                    st_next.switchback_enable = pwdata[pwr_pkg::PM_SWB_BIT];
                end
                pwr_pkg::IDX_CLOCK_SELECT:
                    if (tb_open)
                    begin
                        st_next.wake_delay_sel  = pwdata[pwr_pkg::CS_DLY_LSB +: 3];
                        st_next.clksel = pwdata[pwr_pkg::CS_SEL_LSB +: 2];
                    end
                pwr_pkg::IDX_WAKE_MASK:
                    if (tb_open)
                        st_next.mask = pwdata[7:0];
                pwr_pkg::IDX_TIMED_ACCESS:
                begin
                    st_next.tb_armed = (pwdata[7:0] == pwr_pkg::TB_KEY1);
                    if (st_reg.tb_armed && pwdata[7:0] == pwr_pkg::TB_KEY2)
                        st_next.tb_cnt = pwr_pkg::TB_WINDOW;
                    else if (pwdata[7:0] == pwr_pkg::TB_CLOSE)
                        st_next.tb_cnt = 9'h000;
                end
                default:
                    st_next.pslverr = 1'b0;
            endcase
        end

        if (st_reg.cd == pwr_pkg::CD_SLOW && st_reg.switchback_enable && swb_hit)
            st_next.cd = pwr_pkg::CD_FULL;
        st_next.slow = (st_next.cd == pwr_pkg::CD_SLOW);

        unique case (st_reg.mode)
            pwr_pkg::MODE_RUN:
            begin
                if (st_reg.stop)
                begin
                    st_next.mode          = pwr_pkg::MODE_STOP;
                    st_next.cpu_clk_en    = 1'b0;
                    st_next.periph_clk_en = 1'b0;
                    st_next.osc_en        = 1'b0;
                    st_next.regulator_on  = ~st_reg.sleep;
                end
                else if (st_reg.idle)
                begin
                    st_next.mode       = pwr_pkg::MODE_IDLE;
                    st_next.cpu_clk_en = 1'b0;
                end
                else
                    st_next.cpu_clk_en = (st_reg.cd == pwr_pkg::CD_SLOW)
                                         ? tick : 1'b1;
            end
            pwr_pkg::MODE_IDLE:
                if (idle_exit)
                begin
                    st_next.mode       = pwr_pkg::MODE_RUN;
                    st_next.idle       = 1'b0;
                    st_next.cpu_clk_en = 1'b1;
                    st_next.vec_req    = 1'b1;
                    st_next.vec_id     = first_src(src_act & irq_enable);
                end
            pwr_pkg::MODE_STOP:
                if (wake_any)
                begin
                    st_next.osc_en       = 1'b1;
                    st_next.regulator_on = 1'b1;
                    // stop and sleep cleared by hardware
                    st_next.stop         = 1'b0;
                    st_next.sleep        = 1'b0;
                    st_next.clksel       = pwr_pkg::CLKSEL_INTERNAL_OSC;
                    // vector only if that interrupt is enabled
                    st_next.wake_vec     = |(wake_sel & irq_enable);
                    st_next.wake_id      = first_src(wake_sel & irq_enable);
                    // sleep wake waits for the regulator
                    st_next.dly_cnt      = st_reg.sleep
                                           ? wake_delay(st_reg.wake_delay_sel)
                                           : 14'h0000;
                    st_next.mode         = pwr_pkg::MODE_WAKE;
                end
            pwr_pkg::MODE_WAKE:
                if (st_reg.dly_cnt != 14'h0000)
                    st_next.dly_cnt = st_reg.dly_cnt - 14'h0001;
                else
                begin
                    st_next.mode          = pwr_pkg::MODE_RUN;
                    st_next.cpu_clk_en    = 1'b1;
                    st_next.periph_clk_en = 1'b1;
                    st_next.vec_req       = st_reg.wake_vec;
                    st_next.vec_id        = st_reg.wake_id;
                end
        endcase

        // watchdog reset also ends every mode
        if (wdt_reset)
            st_next = ST_RST;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    // ==========================================================
    // outputs
    assign pready          = st_reg.pready;
    assign prdata          = st_reg.prdata;
    assign pslverr         = st_reg.pslverr;
    assign cpu_clk_en      = st_reg.cpu_clk_en;
    assign periph_clk_en   = st_reg.periph_clk_en;
    assign osc_en          = st_reg.osc_en;
    assign regulator_on    = st_reg.regulator_on;
    assign clk_src_sel     = st_reg.clksel;
    assign slow_clock_mode = st_reg.slow;
    assign vec_req         = st_reg.vec_req;
    assign vec_id          = st_reg.vec_id;

    // ==========================================================
    // checks
    sequence s_stop_wake;
        st_reg.mode == pwr_pkg::MODE_STOP && wake_any && !wdt_reset;
    endsequence

    sequence s_slow_tx;
        slow_clock_mode && st_reg.switchback_enable && uart_tx_load && !wdt_reset;
    endsequence

    mask_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && idx == pwr_pkg::IDX_WAKE_MASK && !tb_open && !wdt_reset
        |=> $stable(st_reg.mask))
        else $error("mask written without unlock");

    wake_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_stop_wake |=> osc_en && st_reg.mode == pwr_pkg::MODE_WAKE)
        else $error("oscillator not restarted on wake");

    wake_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_stop_wake |=> !st_reg.stop && clk_src_sel == pwr_pkg::CLKSEL_INTERNAL_OSC)
        else $error("stop bit or clock select not restored");

    slow_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        slow_clock_mode && cpu_clk_en && st_reg.mode == pwr_pkg::MODE_RUN
        ##1 slow_clock_mode && !wdt_reset |-> !cpu_clk_en [*2])
        else $error("slow clock enable too dense");

    tx_switch_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_slow_tx |=> !slow_clock_mode ##1 !slow_clock_mode)
        else $error("no switchback on transmit load");

    stop_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.mode == pwr_pkg::MODE_STOP
        |-> !cpu_clk_en && !periph_clk_en && !osc_en)
        else $error("clock running in stop");

    idle_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.mode == pwr_pkg::MODE_IDLE && idle_exit && !wdt_reset
        |=> !st_reg.idle && cpu_clk_en && vec_req)
        else $error("idle not left properly");

    vec_enabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_stop_wake and !(|(wake_sel & irq_enable))
        |=> !vec_req [*2])
        else $error("vector for disabled source");

endmodule

`default_nettype wire

// >>> verif/irq_source_model.sv
`timescale 1ns/1ns
`default_nettype none

module irq_source_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // requests from the bench
    input  wire logic [8:0] pin_req,
    input  wire logic [8:0] flag_req,
    input  wire logic       rx_start,
    input  wire logic       tx_req,
    // source side
    output logic [8:0]      ext_pin_n,
    output logic [8:0]      periph_flag,
    output logic            uart_rx_line,
    output logic            uart_tx_load
);
    // ==========================================================
    // source drivers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_pin_n    <= 9'h1ff;
            periph_flag  <= 9'h000;
            uart_rx_line <= 1'b1;
            uart_tx_load <= 1'b0;
        end
        else
        begin
            ext_pin_n    <= ~pin_req;
            periph_flag  <= flag_req;
            uart_rx_line <= ~rx_start;
            uart_tx_load <= tx_req;
        end
    end
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    localparam int WB = 2;
    logic        pclk, presetn, wdt_reset, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, uart_rx_line, uart_rx_enable;
    logic [8:0]  ext_pin_n, periph_flag, irq_enable, irq_blocked;
    logic [8:0]  pin_req, flag_req;
    logic        uart_tx_load, cpu_clk_en, periph_clk_en, osc_en;
    logic        regulator_on, slow_clock_mode, vec_req, rx_start, tx_req;
    logic [1:0]  clk_src_sel;
    logic [3:0]  vec_id;
    int          fail_count, cmp_count, n;
    wire logic [3:0] watch = {vec_req, slow_clock_mode, osc_en, cpu_clk_en};

    power_mode_wake_control #(.WAKE_BASE(WB)) power_mode_wake_control_i (
        .pclk, .presetn, .wdt_reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .ext_pin_n, .periph_flag,
        .irq_enable, .irq_blocked, .uart_rx_line, .uart_rx_enable,
        .uart_tx_load, .cpu_clk_en, .periph_clk_en, .osc_en, .regulator_on,
        .clk_src_sel, .slow_clock_mode, .vec_req, .vec_id);

    irq_source_model irq_source_model_i (
        .pclk, .presetn, .pin_req, .flag_req, .rx_start, .tx_req,
        .ext_pin_n, .periph_flag, .uart_rx_line, .uart_tx_load);

    // ==========================================================
    // shared tasks
    task automatic print_verdict();
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            @(posedge pclk);
            k++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50)
            check(32'h1, 32'h0);
        if (k == 50)
            print_verdict();
    endtask

    // waits for watch bit b to reach v
    task automatic wait_sig(input int b, input logic v);
        n = 0;
        while (watch[b] !== v && n < 300)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n == 300)
            check(32'h1, 32'h0);
        if (n == 300)
            print_verdict();
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        apb(1'b0, pwr_pkg::IDX_WAKE_MASK, 8'h00);
        check(rd, {24'h0, pwr_pkg::WAKE_MASK_RST});
        apb(1'b0, 10'h001, 8'h00);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, pwr_pkg::IDX_WAKE_MASK, 8'h0e);
        apb(1'b0, pwr_pkg::IDX_WAKE_MASK, 8'h00);
        check(rd, 32'hff);
        apb(1'b1, pwr_pkg::IDX_TIMED_ACCESS, pwr_pkg::TB_KEY1);
        apb(1'b1, pwr_pkg::IDX_TIMED_ACCESS, pwr_pkg::TB_KEY2);
        apb(1'b1, pwr_pkg::IDX_WAKE_MASK, 8'hfe);
        apb(1'b1, pwr_pkg::IDX_CLOCK_SELECT, 8'hc1);
        apb(1'b1, pwr_pkg::IDX_TIMED_ACCESS, pwr_pkg::TB_CLOSE);
        apb(1'b1, pwr_pkg::IDX_WAKE_MASK, 8'h00);
        apb(1'b0, pwr_pkg::IDX_WAKE_MASK, 8'h00);
        check(rd, 32'hfe);
        apb(1'b0, pwr_pkg::IDX_CLOCK_SELECT, 8'h00);
        check(rd, 32'hc1);
    endtask

    // stop or sleep, then wake by pins/flags; ve = vector expected
    task automatic t_stop(input logic [7:0] pc, input logic [8:0] pin,
                          input logic [8:0] flg, input logic ve);
        apb(1'b1, pwr_pkg::IDX_POWER_CONTROL, pc);
        wait_sig(1, 1'b0);
        check({cpu_clk_en, periph_clk_en, regulator_on}, {2'b0, ~pc[2]});
        @(posedge pclk);
        pin_req <= 9'h021;
        repeat (20) @(posedge pclk);
        check(osc_en, 1'b0);
        pin_req <= pin;
        flag_req <= flg;
        wait_sig(1, 1'b1);
        check({regulator_on, clk_src_sel}, {1'b1, pwr_pkg::CLKSEL_INTERNAL_OSC});
        wait_sig(0, 1'b1);
        check(n >= (WB << (pwr_pkg::WAKE_DELAY_SEL_RST - 1)) - 2 || !pc[2], 1'b1);
        check({vec_req, vec_id}, {ve, ve ? 4'h2 : 4'h0});
        apb(1'b0, pwr_pkg::IDX_POWER_CONTROL, 8'h00);
        check(rd & 32'h6, 32'h0);
        pin_req <= 9'h000;
        flag_req <= 9'h000;
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_idle();
        irq_enable <= 9'h008;
        apb(1'b1, pwr_pkg::IDX_POWER_CONTROL, 8'h01);
        wait_sig(0, 1'b0);
        check(periph_clk_en, 1'b1);
        @(posedge pclk);
        pin_req <= 9'h008;
        wait_sig(0, 1'b1);
        check({vec_req, vec_id}, {1'b1, 4'h3});
        apb(1'b0, pwr_pkg::IDX_POWER_CONTROL, 8'h00);
        check(rd[0], 1'b0);
        pin_req <= 9'h000;
    endtask

    // k: 0 tx load, 1 rx start, 2 enabled pin, 3 blocked pin, 4 rx disabled
    task automatic t_slow(input int k);
        apb(1'b1, pwr_pkg::IDX_POWER_MODE, 8'he0);
        wait_sig(2, 1'b1);
        check(slow_clock_mode, 1'b1);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        check(n, pwr_pkg::SLOW_DIV - 1);
        @(posedge pclk);
        tx_req <= (k == 0);
        rx_start <= (k == 1 || k == 4);
        uart_rx_enable <= (k != 4);
        irq_blocked <= (k == 3) ? 9'h008 : 9'h000;
        pin_req <= (k == 2 || k == 3) ? 9'h008 : 9'h000;
        @(posedge pclk);
        tx_req <= 1'b0;
        rx_start <= 1'b0;
        if (k < 3)
            wait_sig(2, 1'b0);
        repeat (20) @(posedge pclk);
        check(slow_clock_mode, k >= 3);
        check(slow_clock_mode, k >= 3);
        pin_req <= 9'h000;
        irq_blocked <= 9'h000;
        uart_rx_enable <= 1'b1;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        {presetn, wdt_reset, psel, penable, pwrite, paddr, pwdata} = '0;
        {irq_enable, irq_blocked, pin_req, flag_req, rx_start, tx_req} = '0;
        uart_rx_enable = 1'b1;
        fail_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        irq_enable <= 9'h001;
        t_stop(8'h02, 9'h000, 9'h002, 1'b0);
        irq_enable <= 9'h004;
        t_stop(8'h02, 9'h004, 9'h000, 1'b1);
        t_stop(8'h06, 9'h004, 9'h000, 1'b1);
        t_idle();
        for (int k = 0; k < 5; k++)
            t_slow(k);
        apb(1'b1, pwr_pkg::IDX_POWER_MODE, {pwr_pkg::CD_FULL, 6'h00});
        wait_sig(2, 1'b0);
        check(slow_clock_mode, 1'b0);
        apb(1'b1, pwr_pkg::IDX_POWER_MODE, 8'hc0);
        @(posedge pclk);
        check(slow_clock_mode, 1'b1);
        wdt_reset <= 1'b1;
        @(posedge pclk);
        wdt_reset <= 1'b0;
        repeat (3) @(posedge pclk);
        check(slow_clock_mode, 1'b0);
        apb(1'b0, pwr_pkg::IDX_WAKE_MASK, 8'h00);
        check(rd, {24'h0, pwr_pkg::WAKE_MASK_RST});
        print_verdict();
    end
endmodule

`default_nettype wire
